// File: rtl/flash_program_erase_suspend.v
// program/erase suspend sequencer with command filtering
`timescale 1ns/1ps
`include "flash_suspend_defines.vh"

// Overview of operation
// - suspend is opcode b0, no address; acted on only at chip select release
// - valid suspend halts operation within suspend latency, then shows ready
// - successful suspend sets program or erase paused flag per paused operation
// - release before full opcode or off byte boundary performs no suspend
// - suspend accepted regardless of write enable latch
// - suspend ignored while whole-array erase runs
// - during erase pause, program allowed to a different 2-Mbit sector
// - reads of a paused sector flag undefined data until leaving it
// - program to erase-paused sector aborts and clears write enable latch
// - program during erase pause may pause too; both flags then set
// - no new erase starts while an erase is paused
// - program or erase commands abort while a program is paused
// - other disallowed commands are dropped, write enable latch unchanged
// - suspend unavailable while either auto power-down bit is set
// - array and buffer reads rejected when busy, allowed when paused
// - block and whole-array erases rejected when busy or paused
// - page program, buffer write, buffer program only during erase pause
// - suspend accepted during program or block erase; only program pause during erase pause
// - resume d0 accepted in every state
// - protect, unprotect, otp program, status writes rejected busy or paused
// - status reads, interrupt, terminate always; 3c and 77 only paused
// - paused state allows reads; erase pause also allows programs outside the paused sector
// - terminate aborts any program or erase in progress
module flash_program_erase_suspend #(
  parameter PGM_CYC = 3000,
  parameter ERS_CYC = 20000,
  parameter CHIP_CYC = 200000,
  parameter CNT_W = 24
) (
  input wire i_clk,
  input wire i_rst,
  input wire i_sclk,
  input wire i_cs_n,
  input wire i_si,
  input wire i_auto_deep_powerdown_bit,
  input wire i_auto_ultra_powerdown_bit,
  output reg o_ready_busy_flag,
  output reg o_write_enable_latch,
  output reg o_program_paused_flag,
  output reg o_erase_paused_flag,
  output reg o_read_undefined,
  output reg o_cmd_accepted,
  output reg o_cmd_rejected
);

  // -----------------------------------------------------------
  // states
  // -----------------------------------------------------------
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_PGM = 3'h1;
  localparam [2:0] ST_ERS = 3'h2;
  localparam [2:0] ST_CHIP = 3'h3;
  localparam [2:0] ST_HALT = 3'h4;

  // -----------------------------------------------------------
  // functions
  // -----------------------------------------------------------
  function is_rd4;
    input [7:0] op;
    begin
      is_rd4 = (op == `OP_RD4_A) || (op == `OP_RD4_B) ||
        (op == `OP_RD4_C);
    end
  endfunction

  function [13:0] sec_of;
    input [31:0] a;
    begin
      sec_of = a[`SEC_HI:`SEC_LO];
    end
  endfunction

  // -----------------------------------------------------------
  // pin synchronisers
  // -----------------------------------------------------------
  reg sclk_s1_ff, sclk_s2_ff, sclk_s3_ff;
  reg cs_s1_ff, cs_s2_ff, cs_s3_ff;
  reg si_s1_ff, si_s2_ff;

  always @(posedge i_clk)
  begin
    if (i_rst)
    begin
      sclk_s1_ff <= 1'b0;
      sclk_s2_ff <= 1'b0;
      sclk_s3_ff <= 1'b0;
      cs_s1_ff <= 1'b1;
      cs_s2_ff <= 1'b1;
      cs_s3_ff <= 1'b1;
      si_s1_ff <= 1'b0;
      si_s2_ff <= 1'b0;
    end
    else
    begin
      sclk_s1_ff <= i_sclk;
      sclk_s2_ff <= sclk_s1_ff;
      sclk_s3_ff <= sclk_s2_ff;
      cs_s1_ff <= i_cs_n;
      cs_s2_ff <= cs_s1_ff;
      cs_s3_ff <= cs_s2_ff;
      si_s1_ff <= i_si;
      si_s2_ff <= si_s1_ff;
    end
  end

  wire sclk_rise = sclk_s2_ff & ~sclk_s3_ff;
  wire frame_end = cs_s2_ff & ~cs_s3_ff;

  // -----------------------------------------------------------
  // serial frame capture
  // -----------------------------------------------------------
  reg [2:0] state_ff;
  reg [30:0] shreg_ff;
  reg [2:0] bit_mod_ff;
  reg [2:0] byte_cnt_ff;
  reg [7:0] opcode_ff;
  reg [31:0] addr_ff;
  reg [31:0] rd_addr_ff;
  reg rd_active_ff;

  wire busy = (state_ff != ST_IDLE);
  wire [7:0] byte_in = {shreg_ff[6:0], si_s2_ff};
  wire [31:0] word_in = {shreg_ff, si_s2_ff};

  always @(posedge i_clk)
  begin
    if (i_rst || cs_s2_ff)
    begin
      shreg_ff <= 31'h0;
      bit_mod_ff <= 3'h0;
      byte_cnt_ff <= 3'h0;
      rd_active_ff <= 1'b0;
      if (i_rst)
      begin
        opcode_ff <= 8'h00;
        addr_ff <= 32'h0;
        rd_addr_ff <= 32'h0;
      end
    end
    else if (sclk_rise)
    begin
      shreg_ff <= word_in[30:0];
      bit_mod_ff <= bit_mod_ff + 3'h1;
      if (bit_mod_ff == `BYTE_LAST)
      begin
        if (byte_cnt_ff != `BYTE_LAST)
          byte_cnt_ff <= byte_cnt_ff + 3'h1;
        if (byte_cnt_ff == 3'h0)
          opcode_ff <= byte_in;
        if (byte_cnt_ff == (`BYTES_ADDR4 - 3'h1))
          addr_ff <= word_in;
        // read address tracking, refused while busy
        if (byte_cnt_ff == (`BYTES_RD3 - 3'h1) && opcode_ff == `OP_RD3)
        begin
          rd_addr_ff <= {8'h00, word_in[23:0]};
          rd_active_ff <= ~busy;
        end
        else if (byte_cnt_ff == (`BYTES_ADDR4 - 3'h1) && is_rd4(opcode_ff))
        begin
          rd_addr_ff <= word_in;
          rd_active_ff <= ~busy;
        end
        else if (rd_active_ff)
          rd_addr_ff <= rd_addr_ff + 32'h1;
      end
    end
  end

  // -----------------------------------------------------------
  // operation control
  // -----------------------------------------------------------
  reg [CNT_W-1:0] cnt_ff;
  reg [CNT_W-1:0] prog_rem_ff;
  reg [CNT_W-1:0] ers_rem_ff;
  reg halt_pgm_ff;
  reg wel_ff;
  reg prog_paused_ff;
  reg erase_paused_ff;
  reg [13:0] prog_sec_ff;
  reg [13:0] erase_sec_ff;
  reg acc_ff;
  reg rej_ff;

  wire frame_ok = (bit_mod_ff == 3'h0) && (byte_cnt_ff != 3'h0);
  wire addr_ok = (byte_cnt_ff >= `BYTES_ADDR4);
  wire paused = prog_paused_ff | erase_paused_ff;
  wire pd_bits = i_auto_deep_powerdown_bit | i_auto_ultra_powerdown_bit;
  localparam [31:0] SUSP_CYC_W = `SUSP_LAT_CYC;
  wire [CNT_W-1:0] susp_cyc = SUSP_CYC_W[CNT_W-1:0];
  wire [CNT_W-1:0] pgm_cyc = PGM_CYC[CNT_W-1:0];
  wire [CNT_W-1:0] ers_cyc = ERS_CYC[CNT_W-1:0];
  wire [CNT_W-1:0] chip_cyc = CHIP_CYC[CNT_W-1:0];
  reg [CNT_W-1:0] halt_cnt_ff;

  always @(posedge i_clk)
  begin
    if (i_rst)
    begin
      state_ff <= ST_IDLE;
      cnt_ff <= {CNT_W{1'b0}};
      halt_cnt_ff <= {CNT_W{1'b0}};
      prog_rem_ff <= {CNT_W{1'b0}};
      ers_rem_ff <= {CNT_W{1'b0}};
      halt_pgm_ff <= 1'b0;
      wel_ff <= 1'b0;
      prog_paused_ff <= 1'b0;
      erase_paused_ff <= 1'b0;
      prog_sec_ff <= 14'h0;
      erase_sec_ff <= 14'h0;
      acc_ff <= 1'b0;
      rej_ff <= 1'b0;
    end
    else
    begin
      acc_ff <= 1'b0;
      rej_ff <= 1'b0;
      // running operations and suspend halt
      case (state_ff)
        ST_PGM, ST_ERS, ST_CHIP:
        begin
          if (cnt_ff == {CNT_W{1'b0}})
          begin
            state_ff <= ST_IDLE;
            wel_ff <= 1'b0;
          end
          else
            cnt_ff <= cnt_ff - {{(CNT_W-1){1'b0}}, 1'b1};
        end
        ST_HALT:
        begin
          if (halt_cnt_ff == {CNT_W{1'b0}})
          begin
            state_ff <= ST_IDLE;
            if (halt_pgm_ff)
            begin
              prog_paused_ff <= 1'b1;
              prog_rem_ff <= cnt_ff;
            end
            else
            begin
              erase_paused_ff <= 1'b1;
              ers_rem_ff <= cnt_ff;
            end
          end
          else
            halt_cnt_ff <= halt_cnt_ff - {{(CNT_W-1){1'b0}}, 1'b1};
        end
        default:
        begin
        end
      endcase
      // command executed at chip select release
      if (frame_end && frame_ok)
      begin
        if (opcode_ff == `OP_SUSPEND)
        begin
          if ((state_ff == ST_PGM || state_ff == ST_ERS) && !pd_bits)
          begin
            state_ff <= ST_HALT;
            halt_cnt_ff <= susp_cyc;
            halt_pgm_ff <= (state_ff == ST_PGM);
            acc_ff <= 1'b1;
          end
          else
            rej_ff <= 1'b1;
        end
        else if (opcode_ff == `OP_RESUME)
        begin
          acc_ff <= 1'b1;
          if (state_ff == ST_IDLE && prog_paused_ff)
          begin
            state_ff <= ST_PGM;
            cnt_ff <= prog_rem_ff;
            prog_paused_ff <= 1'b0;
          end
          else if (state_ff == ST_IDLE && erase_paused_ff)
          begin
            state_ff <= ST_ERS;
            cnt_ff <= ers_rem_ff;
            erase_paused_ff <= 1'b0;
          end
        end
        else if (opcode_ff == `OP_TERM)
        begin
          acc_ff <= 1'b1;
          state_ff <= ST_IDLE;
          prog_paused_ff <= 1'b0;
          erase_paused_ff <= 1'b0;
          wel_ff <= 1'b0;
        end
        else if (opcode_ff == `OP_WREN || opcode_ff == `OP_WRDI)
        begin
          if (busy)
            rej_ff <= 1'b1;
          else
          begin
            acc_ff <= 1'b1;
            wel_ff <= (opcode_ff == `OP_WREN);
          end
        end
        else if (is_rd4(opcode_ff) || opcode_ff == `OP_RD3 ||
          opcode_ff == `OP_BUF_RD)
        begin
          acc_ff <= ~busy;
          rej_ff <= busy;
        end
        else if (opcode_ff == `OP_ERS_4K || opcode_ff == `OP_ERS_32K ||
          opcode_ff == `OP_ERS_64K || opcode_ff == `OP_CHIP_A ||
          opcode_ff == `OP_CHIP_B)
        begin
          if (busy || paused)
            rej_ff <= 1'b1;
          else if (!wel_ff || (!addr_ok && opcode_ff != `OP_CHIP_A &&
            opcode_ff != `OP_CHIP_B))
          begin
            rej_ff <= 1'b1;
            wel_ff <= 1'b0;
          end
          else if (opcode_ff == `OP_CHIP_A || opcode_ff == `OP_CHIP_B)
          begin
            acc_ff <= 1'b1;
            state_ff <= ST_CHIP;
            cnt_ff <= chip_cyc;
          end
          else
          begin
            acc_ff <= 1'b1;
            state_ff <= ST_ERS;
            cnt_ff <= ers_cyc;
            erase_sec_ff <= sec_of(addr_ff);
          end
        end
        else if (opcode_ff == `OP_BUF_WR)
        begin
          acc_ff <= ~(busy | prog_paused_ff);
          rej_ff <= busy | prog_paused_ff;
        end
        else if (opcode_ff == `OP_PAGE_PGM || opcode_ff == `OP_BUF_PGM)
        begin
          if (busy || prog_paused_ff)
            rej_ff <= 1'b1;
          else if (!addr_ok || (erase_paused_ff &&
            sec_of(addr_ff) == erase_sec_ff))
          begin
            rej_ff <= 1'b1;
            wel_ff <= 1'b0;
          end
          else if (wel_ff)
          begin
            acc_ff <= 1'b1;
            state_ff <= ST_PGM;
            cnt_ff <= pgm_cyc;
            prog_sec_ff <= sec_of(addr_ff);
          end
          else
            rej_ff <= 1'b1;
        end
        else if (opcode_ff == `OP_PROT || opcode_ff == `OP_UNPROT ||
          opcode_ff == `OP_OTP_PGM || opcode_ff == `OP_WRSR_A ||
          opcode_ff == `OP_WRSR_B || opcode_ff == `OP_WRSC)
        begin
          acc_ff <= ~(busy | paused);
          rej_ff <= busy | paused;
        end
        else if (opcode_ff == `OP_RD_PROT || opcode_ff == `OP_OTP_RD)
        begin
          acc_ff <= ~busy;
          rej_ff <= busy;
        end
        else
          acc_ff <= 1'b1;
      end
    end
  end

  // -----------------------------------------------------------
  // outputs
  // -----------------------------------------------------------
  wire rd_in_paused = (prog_paused_ff &&
    sec_of(rd_addr_ff) == prog_sec_ff) ||
    (erase_paused_ff && sec_of(rd_addr_ff) == erase_sec_ff);

  always @(posedge i_clk)
  begin
    if (i_rst)
    begin
      o_ready_busy_flag <= 1'b0;
      o_write_enable_latch <= 1'b0;
      o_program_paused_flag <= 1'b0;
      o_erase_paused_flag <= 1'b0;
      o_read_undefined <= 1'b0;
      o_cmd_accepted <= 1'b0;
      o_cmd_rejected <= 1'b0;
    end
    else
    begin
      o_ready_busy_flag <= busy;
      o_write_enable_latch <= wel_ff;
      o_program_paused_flag <= prog_paused_ff;
      o_erase_paused_flag <= erase_paused_ff;
      o_read_undefined <= rd_active_ff & rd_in_paused;
      o_cmd_accepted <= acc_ff;
      o_cmd_rejected <= rej_ff;
    end
  end

endmodule // flash_program_erase_suspend

// File: rtl/flash_suspend_defines.vh
// constants for the program/erase suspend sequencer
`ifndef FLASH_SUSPEND_DEFINES_VH
`define FLASH_SUSPEND_DEFINES_VH

// -----------------------------------------------------------
// command opcodes
// -----------------------------------------------------------
`define OP_SUSPEND 8'hb0
`define OP_RESUME 8'hd0
`define OP_WREN 8'h06
`define OP_WRDI 8'h04
`define OP_RD4_A 8'h0b
`define OP_RD4_B 8'h0c
`define OP_RD4_C 8'h13
`define OP_RD3 8'h03
`define OP_BUF_RD 8'hd4
`define OP_ERS_4K 8'h20
`define OP_ERS_32K 8'h52
`define OP_ERS_64K 8'hd8
`define OP_CHIP_A 8'hc7
`define OP_CHIP_B 8'h60
`define OP_PAGE_PGM 8'h02
`define OP_BUF_WR 8'h84
`define OP_BUF_PGM 8'h88
`define OP_PROT 8'h36
`define OP_UNPROT 8'h39
`define OP_OTP_PGM 8'h9b
`define OP_WRSR_A 8'h01
`define OP_WRSR_B 8'h31
`define OP_WRSC 8'h71
`define OP_RDSC 8'h65
`define OP_RDSR 8'h05
`define OP_ASI 8'h25
`define OP_TERM 8'hf0
`define OP_RD_PROT 8'h3c
`define OP_OTP_RD 8'h77

// -----------------------------------------------------------
// frame layout and sector field
// -----------------------------------------------------------
`define BYTE_LAST 3'h7
`define BYTES_RD3 3'h4
`define BYTES_ADDR4 3'h5
`define SEC_HI 31
`define SEC_LO 18

// -----------------------------------------------------------
// timing
// -----------------------------------------------------------
`define CLK_MHZ 10
`define SUSP_LAT_NS 20000
`define SUSP_LAT_CYC ((`SUSP_LAT_NS * `CLK_MHZ) / 1000)

`endif

// File: tb/flash_suspend_checker.sv
// port assertions for the program/erase suspend sequencer
`timescale 1ns/1ps
module flash_suspend_checker (
  input wire i_clk,
  input wire i_rst,
  input wire i_sclk,
  input wire i_cs_n,
  input wire i_si,
  input wire i_auto_deep_powerdown_bit,
  input wire i_auto_ultra_powerdown_bit,
  input wire o_ready_busy_flag,
  input wire o_write_enable_latch,
  input wire o_program_paused_flag,
  input wire o_erase_paused_flag,
  input wire o_read_undefined,
  input wire o_cmd_accepted,
  input wire o_cmd_rejected
);
  reg [9:0] since_ff;
  wire any_cmd;
  assign any_cmd = o_cmd_accepted | o_cmd_rejected;
  // cycles since last accepted command
  always @(posedge i_clk)
  begin
    if (i_rst)
      since_ff <= 10'h3ff;
    else if (o_cmd_accepted)
      since_ff <= 10'h1;
    else if (since_ff != 10'h3ff)
      since_ff <= since_ff + 10'h1;
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  property p_excl;
    !(o_cmd_accepted && o_cmd_rejected);
  endproperty
  property p_pulse;
    any_cmd |=> !any_cmd;
  endproperty
  property p_cs;
    any_cmd |-> $past(i_cs_n) && $past(i_cs_n, 3);
  endproperty
  property p_susp_lat;
    $rose(o_program_paused_flag) || $rose(o_erase_paused_flag)
      |-> since_ff >= 10'd190 && since_ff <= 10'd215;
  endproperty
  property p_ep_ready;
    $rose(o_erase_paused_flag) |-> !o_ready_busy_flag
      && $past(o_ready_busy_flag);
  endproperty
  property p_pp_ready;
    $rose(o_program_paused_flag) |-> !o_ready_busy_flag
      && $past(o_ready_busy_flag);
  endproperty
  property p_wel_rise;
    $rose(o_write_enable_latch) |-> o_cmd_accepted || $past(o_cmd_accepted);
  endproperty
  property p_busy_rise;
    $rose(o_ready_busy_flag) |-> o_cmd_accepted || $past(o_cmd_accepted);
  endproperty
  property p_pp_fall;
    $fell(o_program_paused_flag) |-> o_cmd_accepted
      || $past(o_cmd_accepted);
  endproperty
  property p_rdu;
    o_read_undefined |-> o_program_paused_flag || o_erase_paused_flag;
  endproperty
  a_excl: assert property (p_excl)
    else $error("accept and reject together");
  a_pulse: assert property (p_pulse)
    else $error("response pulse longer than one cycle");
  a_cs: assert property (p_cs)
    else $error("response without chip select release");
  a_susp_lat: assert property (p_susp_lat)
    else $error("pause flag outside suspend latency");
  a_ep_ready: assert property (p_ep_ready)
    else $error("erase pause without ready");
  a_pp_ready: assert property (p_pp_ready)
    else $error("program pause without ready");
  a_wel_rise: assert property (p_wel_rise)
    else $error("write enable latch set without command");
  a_busy_rise: assert property (p_busy_rise)
    else $error("busy without accepted command");
  a_pp_fall: assert property (p_pp_fall)
    else $error("program pause cleared without command");
  a_rdu: assert property (p_rdu)
    else $error("undefined read outside pause");
  c_ep: cover property ($rose(o_erase_paused_flag));
  c_both: cover property (o_program_paused_flag && o_erase_paused_flag);
  c_rdu: cover property ($rose(o_read_undefined));
endmodule // flash_suspend_checker

bind flash_program_erase_suspend flash_suspend_checker chk_u (
  .i_clk(i_clk), .i_rst(i_rst), .i_sclk(i_sclk), .i_cs_n(i_cs_n),
  .i_si(i_si), .i_auto_deep_powerdown_bit(i_auto_deep_powerdown_bit),
  .i_auto_ultra_powerdown_bit(i_auto_ultra_powerdown_bit),
  .o_ready_busy_flag(o_ready_busy_flag),
  .o_write_enable_latch(o_write_enable_latch),
  .o_program_paused_flag(o_program_paused_flag),
  .o_erase_paused_flag(o_erase_paused_flag),
  .o_read_undefined(o_read_undefined),
  .o_cmd_accepted(o_cmd_accepted), .o_cmd_rejected(o_cmd_rejected));

// File: tb/flash_host_model.sv
// host controller model sending serial command frames
`timescale 1ns/1ps
module flash_host_model (
  input wire i_clk,
  output reg o_sclk,
  output reg o_cs_n,
  output reg o_si
);
  integer k;
  initial
  begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_si = 1'b0;
  end
  // ----------------------------------------
  // one frame, msb first, 800 ns bit time
  // ----------------------------------------
  task xfer(input [55:0] d, input integer nb);
  begin
    @(negedge i_clk);
    o_cs_n = 1'b0;
    for (k = 0; k < nb; k = k + 1)
    begin
      o_si = d[55-k];
      repeat (4) @(negedge i_clk);
      o_sclk = 1'b1;
      repeat (4) @(negedge i_clk);
      o_sclk = 1'b0;
    end
    repeat (4) @(negedge i_clk);
    o_cs_n = 1'b1;
    o_si = ~o_si;
    repeat (4) @(negedge i_clk);
  end
  endtask
endmodule // flash_host_model

// File: tb/tb_top.sv
// testbench for the program/erase suspend sequencer
`timescale 1ns/1ps
`include "flash_suspend_defines.vh"
module tb_top;
  localparam A = 2'b01;
  localparam R = 2'b10;
  localparam S1 = 32'h0004_0000;
  localparam S2 = 32'h0008_0000;
  reg i_clk, i_rst, pd_deep, pd_ultra;
  wire sclk, cs_n, si, busy, write_enable_latch, pp, ep, rdu, acc, rej;
  integer mismatches, n_compared, i;
  integer acc0, rej0, rdu0, d;
  integer acc_cnt = 0, rej_cnt = 0, rdu_cnt = 0;
  initial
  begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end
  flash_host_model host_u (.i_clk(i_clk), .o_sclk(sclk), .o_cs_n(cs_n),
    .o_si(si));
  flash_program_erase_suspend #(.PGM_CYC(2000), .ERS_CYC(3000),
    .CHIP_CYC(2500)) dut_u (.i_clk(i_clk), .i_rst(i_rst), .i_sclk(sclk),
    .i_cs_n(cs_n), .i_si(si), .i_auto_deep_powerdown_bit(pd_deep),
    .i_auto_ultra_powerdown_bit(pd_ultra), .o_ready_busy_flag(busy),
    .o_write_enable_latch(write_enable_latch), .o_program_paused_flag(pp),
    .o_erase_paused_flag(ep), .o_read_undefined(rdu),
    .o_cmd_accepted(acc), .o_cmd_rejected(rej));
  // response counters
  always @(posedge i_clk)
  begin
    if (acc === 1'b1) acc_cnt <= acc_cnt + 1;
    if (rej === 1'b1) rej_cnt <= rej_cnt + 1;
    if (rdu === 1'b1) rdu_cnt <= rdu_cnt + 1;
  end
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task check(input [63:0] nm, input [3:0] e, input [3:0] g);
  begin
    n_compared = n_compared + 1;
    if (g !== e)
    begin
      mismatches = mismatches + 1;
      $display("MISMATCH %0s exp %0h got %0h", nm, e, g);
    end
  end
  endtask
  task cmd(input [7:0] op, input [31:0] a, input integer nb,
    input [1:0] e);
  begin
    acc0 = acc_cnt;
    rej0 = rej_cnt;
    rdu0 = rdu_cnt;
    host_u.xfer({op, a, 16'h0}, nb);
    repeat (4) @(negedge i_clk);
    d = acc_cnt - acc0;
    check("accepts", {3'b000, e[0]}, d[3:0]);
    d = rej_cnt - rej0;
    check("rejects", {3'b000, e[1]}, d[3:0]);
  end
  endtask
  task flags(input [3:0] e);
    check("flags", e, {busy, write_enable_latch, pp, ep});
  endtask
  task idle_wait(input integer n);
  begin
    i = 0;
    while (busy !== 1'b0 && i < n)
    begin
      @(negedge i_clk);
      i = i + 1;
    end
  end
  endtask
  task complete_run;
  begin
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  end
  endtask
  initial
  begin
    repeat (30000) @(posedge i_clk);
    mismatches = mismatches + 1;
    complete_run;
  end
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial
  begin
    mismatches = 0;
    n_compared = 0;
    i_rst = 1'b1;
    pd_deep = 1'b0;
    pd_ultra = 1'b0;
    repeat (3) @(negedge i_clk);
    i_rst = 1'b0;
    repeat (4) @(negedge i_clk);
    flags(4'h0);
    cmd(`OP_WREN, 0, 8, A);
    cmd(`OP_ERS_4K, S1, 40, A);
    flags(4'hc);
    cmd(`OP_RD3, 0, 32, R);
    cmd(`OP_WREN, 0, 8, R);
    cmd(`OP_WRDI, 0, 8, R);
    cmd(`OP_OTP_PGM, 0, 8, R);
    cmd(`OP_WRSR_B, 0, 8, R);
    cmd(`OP_ASI, 0, 8, A);
    cmd(`OP_PROT, 0, 8, R);
    cmd(`OP_RDSC, 0, 8, A);
    cmd(`OP_RD_PROT, 0, 8, R);
    cmd(`OP_PAGE_PGM, S2, 40, R);
    cmd(`OP_ERS_32K, S2, 40, R);
    cmd(`OP_RESUME, 0, 8, A);
    pd_deep = 1'b1;
    cmd(`OP_SUSPEND, 0, 8, R);
    pd_deep = 1'b0;
    pd_ultra = 1'b1;
    cmd(`OP_SUSPEND, 0, 8, R);
    pd_ultra = 1'b0;
    cmd(`OP_SUSPEND, 0, 5, 2'b00);
    cmd(`OP_SUSPEND, 0, 12, 2'b00);
    cmd(`OP_SUSPEND, 32'hffff_ffff, 16, A);
    idle_wait(400);
    flags(4'h5);
    $display("test busy and erase pause done");
    cmd(`OP_ERS_64K, S2, 40, R);
    cmd(`OP_WRSR_A, 0, 8, R);
    flags(4'h5);
    cmd(`OP_RD4_A, 32'h0003_ffff, 56, A);
    check("undef", 4'h1, {3'b000, rdu_cnt != rdu0});
    cmd(`OP_RD4_B, S2, 56, A);
    check("undef", 4'h0, {3'b000, rdu_cnt != rdu0});
    cmd(`OP_RD4_C, S2, 40, A);
    cmd(`OP_RD3, 0, 32, A);
    cmd(`OP_BUF_RD, 0, 40, A);
    cmd(`OP_BUF_WR, 0, 40, A);
    cmd(`OP_PAGE_PGM, S1, 40, R);
    flags(4'h1);
    cmd(`OP_WREN, 0, 8, A);
    cmd(`OP_PAGE_PGM, S2, 40, A);
    flags(4'hd);
    cmd(`OP_SUSPEND, 0, 8, A);
    idle_wait(400);
    flags(4'h7);
    $display("test program in erase pause done");
    cmd(`OP_BUF_PGM, 32'h000c_0000, 40, R);
    flags(4'h7);
    cmd(`OP_ERS_4K, 32'h000c_0000, 40, R);
    cmd(`OP_SUSPEND, 0, 8, R);
    cmd(`OP_UNPROT, 0, 8, R);
    cmd(`OP_WRSC, 0, 8, R);
    cmd(`OP_RDSR, 0, 8, A);
    cmd(`OP_OTP_RD, 0, 8, A);
    cmd(`OP_WRDI, 0, 8, A);
    flags(4'h3);
    cmd(`OP_WREN, 0, 8, A);
    cmd(`OP_RESUME, 0, 8, A);
    flags(4'hd);
    cmd(`OP_TERM, 0, 8, A);
    flags(4'h0);
    $display("test program pause done");
    cmd(`OP_WREN, 0, 8, A);
    cmd(`OP_CHIP_A, 0, 8, A);
    flags(4'hc);
    cmd(`OP_SUSPEND, 0, 8, R);
    cmd(`OP_CHIP_B, 0, 8, R);
    idle_wait(3000);
    flags(4'h0);
    $display("test whole-array erase done");
    complete_run;
  end
endmodule // tb_top
